// *** hw/vst_sync_trig.sv ***
// Video sync selection and trigger line control with APB registers
`include "vst_regs.svh"

// Summary of operation
// - External lock mode samples on the external pixel clock, not the internal one.
// - Software sets the polarity of the external pixel clock input.
// - Software sets line sync polarity; external lock uses it as line start.
// - Software sets field sync polarity; external lock uses it as field start.
// - Software sets composite sync polarity; used only in external composite mode.
// - External composite mode drives composite output from its input after polarity and the synchroniser.
// - Standard mode drives composite output from the own sync logic.
// - Each of four input triggers can start or stop acquisition.
// - Software picks rising or falling edge per input trigger.
// - Software can drive each trigger line to a static level.
// - Output triggers show running, complete, line sync or sample clock.
// - Standard mode takes all sync and pixel clock from the composite video.
module vst_sync_trig
    import vst_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External connector inputs
    input wire logic ext_pixel_clock_in,
    input wire logic ext_line_sync_in,
    input wire logic ext_field_sync_in,
    input wire logic ext_composite_sync_in,
    // Own sync separator, same clock
    input wire logic int_composite_sync,
    input wire logic int_line_sync,
    input wire logic int_field_sync,
    input wire logic int_pixel_clock,
    // Acquisition engine, same clock
    input wire logic acq_running_flag,
    input wire logic acq_complete_flag,
    // Trigger pins
    input wire logic [`VST_NUM_TRIG-1:0] trigger_lines_in,
    output logic [`VST_NUM_TRIG-1:0] trigger_lines_out,
    output logic [`VST_NUM_TRIG-1:0] trigger_lines_oe,
    // Selected timing towards the converter
    output logic composite_sync_out,
    output logic sample_clock,
    output logic line_sync,
    output logic field_sync,
    output logic sample_strobe,
    output logic line_start_pulse,
    output logic field_start_pulse,
    // Acquisition control
    output logic acq_start_pulse,
    output logic acq_stop_pulse,
    output logic irq
);

    // Condition vector bit positions
    localparam int unsigned CB_PCLK = 0;
    localparam int unsigned CB_LINE = 1;
    localparam int unsigned CB_FIELD = 2;
    localparam int unsigned CB_CSYNC = 3;
    localparam int unsigned CB_TRIG = 4;

    logic [31:0] ctrl_q;
    logic [31:0] trig_q;
    logic [31:0] prdata_q;
    logic [`VST_NUM_EV-1:0] rd_clr_q;
    vst_mode_e mode;
    logic setup;
    logic access;
    logic wr_fire;
    logic rd_fire;
    logic mapped;
    logic [31:0] rd_mux;
    logic [`VST_NUM_EV-1:0] ev_set;
    logic [`VST_NUM_EV-1:0] ev_clr;
    logic [`VST_NUM_EV-1:0] irq_status;
    logic [`VST_NUM_EV-1:0] irq_mask;
    logic sw_start;
    logic sw_stop;
    logic [`VST_NUM_TRIG-1:0] trig_start;
    logic [`VST_NUM_TRIG-1:0] trig_stop;
    logic [`VST_NUM_TRIG-1:0] trig_out_d;
    logic sel_pclk;
    logic sel_line;
    logic sel_field;
    logic csync_d;
    logic int_pclk_prev_q;
    logic int_line_prev_q;
    logic int_field_prev_q;
    logic pclk_edge;
    logic line_edge;
    logic field_edge;
    logic complete_prev_q;
    logic composite_sync_q;
    logic sample_clock_q;
    logic line_sync_q;
    logic field_sync_q;
    logic sample_strobe_q;
    logic line_start_q;
    logic field_start_q;
    logic acq_start_q;
    logic acq_stop_q;
    logic [`VST_NUM_TRIG-1:0] trig_out_q;
    logic [`VST_NUM_TRIG-1:0] trig_oe_q;

    vst_cond_if cif ();

    // APB phase decode
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign mapped = (paddr == `VST_CTRL_OFS) || (paddr == `VST_TRIG_OFS) ||
                    (paddr == `VST_CMD_OFS) || (paddr == `VST_STATUS_OFS) ||
                    (paddr == `VST_MASK_OFS) || (paddr == `VST_STATE_OFS);
    assign wr_fire = access & pwrite & mapped;
    assign rd_fire = access & ~pwrite & mapped;
    assign pready = access;
    assign pslverr = access & ~mapped;
    assign mode = vst_mode_e'(ctrl_q[`VST_CTRL_MODE_LSB +: 2]);

    // Control register: mode and input polarities
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `VST_CTRL_RST;
        end else if (wr_fire && paddr == `VST_CTRL_OFS) begin
            ctrl_q <= {26'h000_0000, pwdata[5:0]};
        end
    end

    // Trigger configuration, one byte per line
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            trig_q <= `VST_TRIG_RST;
        end else if (wr_fire && paddr == `VST_TRIG_OFS) begin
            trig_q <= pwdata;
        end
    end

    // Software start and stop commands
    assign sw_start = wr_fire && paddr == `VST_CMD_OFS && pwdata[`VST_CMD_START];
    assign sw_stop = wr_fire && paddr == `VST_CMD_OFS && pwdata[`VST_CMD_STOP];

    // Read data mux, sampled in the setup cycle
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `VST_CTRL_OFS: rd_mux = ctrl_q;
            `VST_TRIG_OFS: rd_mux = trig_q;
            `VST_STATUS_OFS: rd_mux[`VST_NUM_EV-1:0] = irq_status;
            `VST_MASK_OFS: rd_mux[`VST_NUM_EV-1:0] = irq_mask;
            `VST_STATE_OFS: rd_mux = {20'h0_0000, cif.level[CB_TRIG +: `VST_NUM_TRIG],
                                      sample_clock_q, field_sync_q, line_sync_q,
                                      composite_sync_q, 2'h0,
                                      acq_complete_flag, acq_running_flag};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data register and captured status bits
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata_q <= 32'h0000_0000;
            rd_clr_q <= '0;
        end else if (setup) begin
            prdata_q <= rd_mux;
            rd_clr_q <= (paddr == `VST_STATUS_OFS) ? irq_status : '0;
        end
    end

    assign prdata = prdata_q;

    // Read clears only the status bits actually returned
    assign ev_clr = rd_fire && paddr == `VST_STATUS_OFS ? rd_clr_q : '0;

    // External inputs into the conditioner
    assign cif.raw = {trigger_lines_in, ext_composite_sync_in, ext_field_sync_in,
                      ext_line_sync_in, ext_pixel_clock_in};
    assign cif.invert = {4'h0, ctrl_q[`VST_CTRL_CSYNC_POL], ctrl_q[`VST_CTRL_FIELD_POL],
                         ctrl_q[`VST_CTRL_LINE_POL], ctrl_q[`VST_CTRL_PCLK_POL]};

    // Polarity, synchroniser, edge detect
    vst_in_cond u_cond (
        .clock(clock),
        .nrst(nrst),
        .c(cif.cond)
    );

    // Previous own sync and acquisition complete levels for edge finding
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            int_pclk_prev_q <= 1'b0;
            int_line_prev_q <= 1'b0;
            int_field_prev_q <= 1'b0;
            complete_prev_q <= 1'b0;
        end else begin
            int_pclk_prev_q <= int_pixel_clock;
            int_line_prev_q <= int_line_sync;
            int_field_prev_q <= int_field_sync;
            complete_prev_q <= acq_complete_flag;
        end
    end

    // Timing source selection by mode
    always_comb begin
        if (mode == VST_MODE_EXT_LOCK) begin
            sel_pclk = cif.level[CB_PCLK];
            sel_line = cif.level[CB_LINE];
            sel_field = cif.level[CB_FIELD];
            pclk_edge = cif.rise[CB_PCLK];
            line_edge = cif.rise[CB_LINE];
            field_edge = cif.rise[CB_FIELD];
        end else begin
            sel_pclk = int_pixel_clock;
            sel_line = int_line_sync;
            sel_field = int_field_sync;
            pclk_edge = int_pixel_clock & ~int_pclk_prev_q;
            line_edge = int_line_sync & ~int_line_prev_q;
            field_edge = int_field_sync & ~int_field_prev_q;
        end
    end

    // Composite sync output source
    always_comb begin
        if (mode == VST_MODE_CSYNC_EXT) begin
            csync_d = cif.level[CB_CSYNC];
        end else begin
            csync_d = int_composite_sync;
        end
    end

    // Registered timing outputs
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            composite_sync_q <= 1'b0;
            sample_clock_q <= 1'b0;
            line_sync_q <= 1'b0;
            field_sync_q <= 1'b0;
            sample_strobe_q <= 1'b0;
            line_start_q <= 1'b0;
            field_start_q <= 1'b0;
        end else begin
            composite_sync_q <= csync_d;
            sample_clock_q <= sel_pclk;
            line_sync_q <= sel_line;
            field_sync_q <= sel_field;
            sample_strobe_q <= pclk_edge;
            line_start_q <= line_edge;
            field_start_q <= field_edge;
        end
    end

    assign composite_sync_out = composite_sync_q;
    assign sample_clock = sample_clock_q;
    assign line_sync = line_sync_q;
    assign field_sync = field_sync_q;
    assign sample_strobe = sample_strobe_q;
    assign line_start_pulse = line_start_q;
    assign field_start_pulse = field_start_q;

    // Per-line input edge handling and output source mux
    genvar t;
    generate
        for (t = 0; t < `VST_NUM_TRIG; t++) begin : g_trig
            logic [7:0] cfg;
            logic hit;
            vst_act_e act;
            vst_src_e src;

            assign cfg = trig_q[8*t +: 8];
            assign act = vst_act_e'(cfg[`VST_TRIG_ACT_LSB +: 2]);
            assign src = vst_src_e'(cfg[`VST_TRIG_SRC_LSB +: 2]);
            // Selected edge of an undriven line
            assign hit = ~cfg[`VST_TRIG_DRIVE] &
                         (cfg[`VST_TRIG_FALL] ? cif.fall[CB_TRIG + t]
                                              : cif.rise[CB_TRIG + t]);
            assign trig_start[t] = hit & (act == VST_ACT_START);
            assign trig_stop[t] = hit & (act == VST_ACT_STOP);

            // Static level or status source
            always_comb begin
                if (cfg[`VST_TRIG_STATIC]) begin
                    trig_out_d[t] = cfg[`VST_TRIG_LEVEL];
                end else begin
                    unique case (src)
                        VST_SRC_RUNNING: trig_out_d[t] = acq_running_flag;
                        VST_SRC_COMPLETE: trig_out_d[t] = acq_complete_flag;
                        VST_SRC_LINE_SYNC: trig_out_d[t] = sel_line;
                        VST_SRC_SAMPLE_CLK: trig_out_d[t] = sel_pclk;
                    endcase
                end
            end
        end
    endgenerate

    // Trigger pin drivers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            trig_out_q <= '0;
            trig_oe_q <= '0;
        end else begin
            trig_out_q <= trig_out_d;
            for (int k = 0; k < `VST_NUM_TRIG; k++) begin
                trig_oe_q[k] <= trig_q[8*k + `VST_TRIG_DRIVE];
            end
        end
    end

    assign trigger_lines_out = trig_out_q;
    assign trigger_lines_oe = trig_oe_q;

    // Acquisition start and stop requests
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acq_start_q <= 1'b0;
            acq_stop_q <= 1'b0;
        end else begin
            acq_start_q <= sw_start | (|trig_start);
            acq_stop_q <= sw_stop | (|trig_stop);
        end
    end

    assign acq_start_pulse = acq_start_q;
    assign acq_stop_pulse = acq_stop_q;

    // Interrupt events
    always_comb begin
        ev_set = '0;
        ev_set[`VST_EV_TRIG_START] = |trig_start;
        ev_set[`VST_EV_TRIG_STOP] = |trig_stop;
        ev_set[`VST_EV_ACQ_DONE] = acq_complete_flag & ~complete_prev_q;
        ev_set[`VST_EV_FIELD] = field_edge;
    end

    // Sticky status, mask and interrupt line
    vst_irq u_irq (
        .clock(clock),
        .nrst(nrst),
        .event_set(ev_set),
        .event_clr(ev_clr),
        .mask_wr(wr_fire && paddr == `VST_MASK_OFS),
        .mask_wdata(pwdata[`VST_NUM_EV-1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

endmodule

// *** hw/vst_regs.svh ***
// Register offsets, field positions and reset values of the sync and trigger block
`ifndef VST_REGS_SVH
`define VST_REGS_SVH

// Register byte offsets
`define VST_CTRL_OFS 8'h00
`define VST_TRIG_OFS 8'h04
`define VST_CMD_OFS 8'h08
`define VST_STATUS_OFS 8'h0C
`define VST_MASK_OFS 8'h10
`define VST_STATE_OFS 8'h14

// Control register fields
`define VST_CTRL_MODE_LSB 0
`define VST_CTRL_PCLK_POL 2
`define VST_CTRL_LINE_POL 3
`define VST_CTRL_FIELD_POL 4
`define VST_CTRL_CSYNC_POL 5
`define VST_CTRL_RST 32'h0000_0000

// Trigger configuration: one byte per line
`define VST_TRIG_DRIVE 0
`define VST_TRIG_FALL 1
`define VST_TRIG_ACT_LSB 2
`define VST_TRIG_STATIC 4
`define VST_TRIG_LEVEL 5
`define VST_TRIG_SRC_LSB 6
`define VST_TRIG_RST 32'h0000_0000

// Command register fields, write-only pulses
`define VST_CMD_START 0
`define VST_CMD_STOP 1

// Interrupt status bits
`define VST_EV_TRIG_START 0
`define VST_EV_TRIG_STOP 1
`define VST_EV_ACQ_DONE 2
`define VST_EV_FIELD 3
`define VST_NUM_EV 4
`define VST_MASK_RST 4'h0

// Conditioned external inputs: pixel clock, line, field, csync, four triggers
`define VST_NUM_COND 8
`define VST_NUM_TRIG 4

`endif

// *** hw/vst_pkg.sv ***
// Types shared by the sync and trigger block
package vst_pkg;

    // Acquisition timing source
    typedef enum logic [1:0] {
        VST_MODE_STANDARD = 2'h0,
        VST_MODE_CSYNC_EXT = 2'h1,
        VST_MODE_EXT_LOCK = 2'h2,
        VST_MODE_SPARE = 2'h3
    } vst_mode_e;

    // Action taken on an input trigger edge
    typedef enum logic [1:0] {
        VST_ACT_NONE = 2'h0,
        VST_ACT_START = 2'h1,
        VST_ACT_STOP = 2'h2,
        VST_ACT_SPARE = 2'h3
    } vst_act_e;

    // Source shown on an output trigger line
    typedef enum logic [1:0] {
        VST_SRC_RUNNING = 2'h0,
        VST_SRC_COMPLETE = 2'h1,
        VST_SRC_LINE_SYNC = 2'h2,
        VST_SRC_SAMPLE_CLK = 2'h3
    } vst_src_e;

endpackage

// *** hw/vst_cond_if.sv ***
// Carrier between the top and the input conditioner
`include "vst_regs.svh"
interface vst_cond_if;
    logic [`VST_NUM_COND-1:0] raw;
    logic [`VST_NUM_COND-1:0] invert;
    logic [`VST_NUM_COND-1:0] level;
    logic [`VST_NUM_COND-1:0] rise;
    logic [`VST_NUM_COND-1:0] fall;

    modport cond (input raw, input invert, output level, output rise, output fall);
    modport user (output raw, output invert, input level, input rise, input fall);
endinterface

// *** hw/vst_in_cond.sv ***
// Polarity, two-stage synchroniser and edge detect for external inputs
`include "vst_regs.svh"
module vst_in_cond
    import vst_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    vst_cond_if.cond c
);

    logic [`VST_NUM_COND-1:0] meta_q;
    logic [`VST_NUM_COND-1:0] sync_q;
    logic [`VST_NUM_COND-1:0] prev_q;
    logic [`VST_NUM_COND-1:0] rise_q;
    logic [`VST_NUM_COND-1:0] fall_q;

    genvar i;
    generate
        for (i = 0; i < `VST_NUM_COND; i++) begin : g_bit
            // Polarity before the flops, edges only after the second stage
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                    prev_q[i] <= 1'b0;
                    rise_q[i] <= 1'b0;
                    fall_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= c.raw[i] ^ c.invert[i];
                    sync_q[i] <= meta_q[i];
                    prev_q[i] <= sync_q[i];
                    rise_q[i] <= sync_q[i] & ~prev_q[i];
                    fall_q[i] <= ~sync_q[i] & prev_q[i];
                end
            end
        end
    endgenerate

    // Outputs all from flops
    assign c.level = prev_q;
    assign c.rise = rise_q;
    assign c.fall = fall_q;

endmodule

// *** hw/vst_irq.sv ***
// Sticky event status, mask and level interrupt
`include "vst_regs.svh"
module vst_irq
    import vst_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [`VST_NUM_EV-1:0] event_set,
    input wire logic [`VST_NUM_EV-1:0] event_clr,
    input wire logic mask_wr,
    input wire logic [`VST_NUM_EV-1:0] mask_wdata,
    output logic [`VST_NUM_EV-1:0] status,
    output logic [`VST_NUM_EV-1:0] mask,
    output logic irq
);

    logic [`VST_NUM_EV-1:0] status_q;
    logic [`VST_NUM_EV-1:0] mask_q;
    logic irq_q;

    // Set beats a clear in the same cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~event_clr) | event_set;
        end
    end

    // Mask register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mask_q <= `VST_MASK_RST;
        end else if (mask_wr) begin
            mask_q <= mask_wdata;
        end
    end

    // Registered interrupt level
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(((status_q & ~event_clr) | event_set) & mask_q);
        end
    end

    assign status = status_q;
    assign mask = mask_q;
    assign irq = irq_q;

endmodule

// *** verif/vst_sync_trig_monitor.sv ***
// Checker of sync selection and trigger line outputs at the top ports
`include "vst_regs.svh"
module vst_sync_trig_monitor
    import vst_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic ext_pixel_clock_in,
    input wire logic ext_line_sync_in,
    input wire logic ext_field_sync_in,
    input wire logic ext_composite_sync_in,
    input wire logic int_composite_sync,
    input wire logic int_line_sync,
    input wire logic int_field_sync,
    input wire logic int_pixel_clock,
    input wire logic acq_running_flag,
    input wire logic [`VST_NUM_TRIG-1:0] trigger_lines_out,
    input wire logic [`VST_NUM_TRIG-1:0] trigger_lines_oe,
    input wire logic composite_sync_out,
    input wire logic sample_clock,
    input wire logic line_sync,
    input wire logic field_sync
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] ctrl_q;
    logic [31:0] trig_q;
    logic [2:0] age_q;
    logic wr;
    logic ok;
    logic [1:0] md;
    assign wr = psel && penable && pwrite;
    assign ok = age_q >= 3'h4;
    assign md = ctrl_q[1:0];
    // Shadow of the control word
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= 32'h0000_0000;
        end else if (wr && paddr == `VST_CTRL_OFS) begin
            ctrl_q <= pwdata;
        end
    end
    // Shadow of the trigger word
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            trig_q <= 32'h0000_0000;
        end else if (wr && paddr == `VST_TRIG_OFS) begin
            trig_q <= pwdata;
        end
    end
    // Cycles since reset or the last setting change, saturating
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            age_q <= 3'h0;
        end else if (wr && (paddr == `VST_CTRL_OFS || paddr == `VST_TRIG_OFS)) begin
            age_q <= 3'h0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_csync_ext_pass: assert property (
        ok && md == 2'h1 |-> composite_sync_out == $past(ext_composite_sync_in ^ ctrl_q[5], 4))
        else $error("composite out not following external input");
    a_csync_std_own: assert property (
        ok && md == 2'h0 |-> composite_sync_out == $past(int_composite_sync))
        else $error("composite out not from own sync logic");
    a_lock_pixel_clock: assert property (
        ok && md == 2'h2 |-> sample_clock == $past(ext_pixel_clock_in ^ ctrl_q[2], 4))
        else $error("sample clock not from external pixel clock");
    a_lock_line_pol: assert property (
        ok && md == 2'h2 |-> line_sync == $past(ext_line_sync_in ^ ctrl_q[3], 4))
        else $error("line sync polarity wrong");
    a_lock_field_pol: assert property (
        ok && md == 2'h2 |-> field_sync == $past(ext_field_sync_in ^ ctrl_q[4], 4))
        else $error("field sync polarity wrong");
    a_std_own_timing: assert property (
        ok && md == 2'h0 |-> sample_clock == $past(int_pixel_clock)
        && line_sync == $past(int_line_sync) && field_sync == $past(int_field_sync))
        else $error("standard timing not from own separator");
    a_trig_drive_enable: assert property (
        ok |-> trigger_lines_oe == {trig_q[24], trig_q[16], trig_q[8], trig_q[0]})
        else $error("trigger enable not as set");
    a_trig_static_level: assert property (
        ok && trig_q[0] && trig_q[4] |-> trigger_lines_out[0] == trig_q[5])
        else $error("static trigger level wrong");
    a_trig_running_src: assert property (
        ok && trig_q[16] && !trig_q[20] && trig_q[23:22] == 2'h0
        |-> trigger_lines_out[2] == $past(acq_running_flag))
        else $error("trigger not showing running flag");
    a_trig_sync_src: assert property (
        ok && trig_q[0] && trig_q[7:4] == 4'h8 |-> trigger_lines_out[0] == line_sync
        && (!trig_q[8] || trig_q[15:12] != 4'hC || trigger_lines_out[1] == sample_clock))
        else $error("trigger not showing sync source");
endmodule

bind vst_sync_trig vst_sync_trig_monitor vst_sync_trig_monitor_i (.*);

// *** verif/vst_cam_model.sv ***
// Camera timing source: pixel clock, line, field and composite sync
module vst_cam_model (
    input wire logic run,
    output logic pclk,
    output logic line,
    output logic field,
    output logic csync
);
    timeunit 1ns;
    timeprecision 100ps;
    int px;
    // Clock stands still between frames; phase unrelated to the bench clock
    initial begin
        pclk = 1'b0;
        line = 1'b0;
        field = 1'b0;
        csync = 1'b0;
        px = 0;
        #3;
        forever begin
            #62.5;
            if (run) begin
                pclk = !pclk;
                px = px + 1;
                line = (px % 24) < 4;
                field = (px % 240) < 30;
                csync = line ^ field;
            end
        end
    end
endmodule

// *** verif/vst_sync_trig_tb.sv ***
// Self-checking bench of the sync and trigger block over APB
`include "vst_regs.svh"
module vst_sync_trig_tb;
    import vst_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic nrst, psel, penable, pwrite, pready, pslverr, irq, cam_run;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] trigger_lines_in, trigger_lines_out, trigger_lines_oe;
    logic pck, lin, fld, csy, acq_running_flag, acq_complete_flag;
    logic csync_o, sclk, lsync, fsync, sstb, lsp, fsp, st_p, sp_p, e;
    logic [7:0] cnt = 8'h00;
    int err_total = 0;
    int comparisons = 0;
    int st_cnt = 0;
    int sp_cnt = 0;
    always #5 clock = !clock;
    vst_cam_model vst_cam_model_i (.run(cam_run), .pclk(pck), .line(lin),
        .field(fld), .csync(csy));
    vst_sync_trig vst_sync_trig_i (.clock(clock), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_pixel_clock_in(pck), .ext_line_sync_in(lin), .ext_field_sync_in(fld),
        .ext_composite_sync_in(csy), .int_composite_sync(cnt[4] ^ cnt[7]),
        .int_line_sync(cnt[4]), .int_field_sync(cnt[7]), .int_pixel_clock(cnt[0]),
        .acq_running_flag(acq_running_flag), .acq_complete_flag(acq_complete_flag),
        .trigger_lines_in(trigger_lines_in), .trigger_lines_out(trigger_lines_out),
        .trigger_lines_oe(trigger_lines_oe), .composite_sync_out(csync_o),
        .sample_clock(sclk), .line_sync(lsync), .field_sync(fsync),
        .sample_strobe(sstb), .line_start_pulse(lsp), .field_start_pulse(fsp),
        .acq_start_pulse(st_p), .acq_stop_pulse(sp_p), .irq(irq));
    // Own separator pattern and pulse counters
    always @(posedge clock) begin
        cnt <= cnt + 8'h01;
        if (st_p === 1'b1) st_cnt++;
        if (sp_p === 1'b1) sp_cnt++;
    end
    task automatic give_verdict();
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            err_total++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n == 20) err_total++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Watchdog
    initial begin
        #100us;
        err_total++;
        give_verdict();
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, cam_run} = '0;
        {trigger_lines_in, acq_running_flag, acq_complete_flag} = '0;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        apb(1'b0, `VST_CTRL_OFS, 32'h0);
        chk(r, `VST_CTRL_RST);
        apb(1'b0, `VST_TRIG_OFS, 32'h0);
        chk(r, `VST_TRIG_RST);
        apb(1'b0, `VST_MASK_OFS, 32'h0);
        chk(r, 32'h0000_0000);
        apb(1'b1, 8'h20, 32'hFFFF_FFFF);
        chk(e, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk(r, 32'h0);
        chk(e, 32'h1);
        // Standard, external composite and external lock modes, polarities plain and inverted, with camera frames
        for (int m = 0; m < 6; m++) begin
            apb(1'b1, `VST_CTRL_OFS, (m % 3) | (m > 2 ? 32'h3C : 32'h0));
            apb(1'b0, `VST_CTRL_OFS, 32'h0);
            chk(r, (m % 3) | (m > 2 ? 32'h3C : 32'h0));
            cam_run <= 1'b1;
            idle(250);
            cam_run <= 1'b0;
            idle(10);
        end
        // Input triggers: line 0 starts on rise, line 1 stops on fall
        apb(1'b1, `VST_CTRL_OFS, 32'h0);
        apb(1'b1, `VST_MASK_OFS, 32'h1);
        apb(1'b1, `VST_TRIG_OFS, 32'h0000_0A04);
        trigger_lines_in <= 4'h2;
        idle(12);
        chk(sp_cnt, 0);
        trigger_lines_in <= 4'h3;
        idle(12);
        chk(st_cnt, 1);
        chk(irq, 1);
        trigger_lines_in <= 4'h1;
        idle(12);
        chk(sp_cnt, 1);
        apb(1'b0, `VST_STATUS_OFS, 32'h0);
        chk(r & 32'h3, 32'h3);
        apb(1'b0, `VST_STATUS_OFS, 32'h0);
        chk(r & 32'h3, 32'h0);
        idle(2);
        chk(irq, 0);
        // Output lines: static high, static low, running, complete
        apb(1'b1, `VST_TRIG_OFS, 32'h4105_1131);
        trigger_lines_in <= 4'h5;
        acq_running_flag <= 1'b1;
        idle(12);
        chk(st_cnt, 1);
        chk(trigger_lines_oe, 32'hF);
        chk(trigger_lines_out[1:0], 32'h1);
        acq_complete_flag <= 1'b1;
        idle(4);
        chk(trigger_lines_out[3], 32'h1);
        apb(1'b0, `VST_STATE_OFS, 32'h0);
        chk(r & 32'h3, 32'h3);
        apb(1'b0, `VST_STATUS_OFS, 32'h0);
        chk(r & 32'h4, 32'h4);
        acq_running_flag <= 1'b0;
        // Line sync and sample clock sources in external lock
        apb(1'b1, `VST_TRIG_OFS, 32'h0000_C181);
        apb(1'b1, `VST_CTRL_OFS, 32'h2);
        cam_run <= 1'b1;
        idle(200);
        cam_run <= 1'b0;
        // Software start and stop commands
        apb(1'b1, `VST_CMD_OFS, 32'h1);
        apb(1'b1, `VST_CMD_OFS, 32'h2);
        apb(1'b0, `VST_CMD_OFS, 32'h0);
        chk(r, 32'h0);
        chk(st_cnt, 2);
        chk(sp_cnt, 2);
        give_verdict();
    end
endmodule
